// ==== rtl/gate_timer_pkg.sv ====
// package: register map, field positions, reset values and gate source codes for the gated timer
package gate_timer_pkg;

	localparam logic [2:0] ADDR_COUNT_LOW   = 3'h0;
	localparam logic [2:0] ADDR_COUNT_HIGH  = 3'h1;
	localparam logic [2:0] ADDR_TIMER_CTRL  = 3'h2;
	localparam logic [2:0] ADDR_GATE_CTRL   = 3'h3;
	localparam logic [2:0] ADDR_PERIPH_FLAG = 3'h4;
	localparam logic [2:0] ADDR_PERIPH_EN   = 3'h5;
	localparam logic [2:0] ADDR_IRQ_CTRL    = 3'h6;

	// timer_control_reg fields
	localparam int TC_TIMER_ON  = 0;
	localparam int TC_NO_SYNC   = 2;
	localparam int TC_OSC_EN    = 3;
	localparam int TC_CLK_SEL_L = 6;
	// gate_control_reg fields
	localparam int GC_SRC_L     = 0;
	localparam int GC_LEVEL     = 2;
	localparam int GC_ARM_DONE  = 3;
	localparam int GC_SPM       = 4;
	localparam int GC_TOGGLE    = 5;
	localparam int GC_POL       = 6;
	localparam int GC_ENABLE    = 7;
	// flag / enable fields
	localparam int PF_OVF       = 0;
	localparam int PF_GATE      = 7;
	localparam int IC_PERIPH    = 6;
	localparam int IC_GLOBAL    = 7;
	// comparator sync select lives in bits 0/1 of the irq-control spare space is avoided: own reg
	localparam logic [2:0] ADDR_CMP_SYNC = 3'h7;

	localparam logic [7:0] TIMER_CTRL_RST = 8'h00;
	localparam logic [7:0] GATE_CTRL_RST  = 8'h00;
	localparam logic [7:0] FLAG_RST       = 8'h00;
	localparam logic [7:0] EN_RST         = 8'h00;
	localparam logic [1:0] CMP_SYNC_RST   = 2'h3;
	localparam logic [15:0] COUNT_MAX     = 16'hffff;
	localparam logic [7:0] TIMER8_MAX     = 8'hff;

	typedef enum logic [1:0] {
		SRC_PIN,
		SRC_TIMER8_OVF,
		SRC_CMP_ONE,
		SRC_CMP_TWO
	} gate_src_t;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;

	typedef struct packed {
		logic gate_input_pin;
		logic cmp_one;
		logic cmp_two;
		logic [7:0] timer8;
		logic timer8_tick;
	} gate_inputs_t;

endpackage : gate_timer_pkg

// ==== rtl/gate_timer.sv ====
// gated 16-bit timer/counter with gate modes, overflow flag and register port
`timescale 1ns/1ps

module gate_timer
	import gate_timer_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	// clock, reset, enable
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         clk_en,
	// register port
	input  wire bus_req_t     bus_req,
	output logic [7:0]        rdata,
	// count clock tick (selected source, one mclk pulse per rising edge) and sleep state
	input  wire logic         count_tick,
	input  wire logic         sleep_mode,
	// gate sources
	input  wire gate_inputs_t gate_in,
	// interrupt, wake, oscillator run and gate level outputs
	output logic              irq_req,
	output logic              wake_req,
	output logic              wake_vector,
	output logic              osc_run,
	output logic              gate_level
);

	// =====================================================================
	// registers
	logic [COUNT_W-1:0] count_q, count_d;
	logic [7:0] tctrl_q, gctrl_q, flag_q, en_q, ictrl_q;
	logic [1:0] cmp_sync_q;
	logic [7:0] rdata_q, rdata_d;
	logic [1:0] pin_sy_q, c1_sy_q, c2_sy_q;
	logic       c1_rt_q, c2_rt_q;
	logic       t8_wrap_q, t8_prev_q;
	logic       gate_prev_q, toggle_q, level_q, level_prev_q;
	logic       irq_q, wake_q, vec_q, osc_q;

	// =====================================================================
	// decode
	function automatic logic wr_hit(input bus_req_t req, input logic [2:0] a);
		return req.wr && (req.addr == a);
	endfunction : wr_hit

	wire logic wr_lo  = wr_hit(bus_req, ADDR_COUNT_LOW);
	wire logic wr_hi  = wr_hit(bus_req, ADDR_COUNT_HIGH);
	wire logic wr_tc  = wr_hit(bus_req, ADDR_TIMER_CTRL);
	wire logic wr_gc  = wr_hit(bus_req, ADDR_GATE_CTRL);
	wire logic wr_pf  = wr_hit(bus_req, ADDR_PERIPH_FLAG);
	wire logic wr_pe  = wr_hit(bus_req, ADDR_PERIPH_EN);
	wire logic wr_ic  = wr_hit(bus_req, ADDR_IRQ_CTRL);
	wire logic wr_cs  = wr_hit(bus_req, ADDR_CMP_SYNC);

	wire logic timer_on   = tctrl_q[TC_TIMER_ON];
	wire logic no_sync    = tctrl_q[TC_NO_SYNC];
	wire logic ext_clk    = tctrl_q[TC_CLK_SEL_L+1];
	wire logic gate_en    = gctrl_q[GC_ENABLE];
	wire logic gate_pol   = gctrl_q[GC_POL];
	wire logic toggle_en  = gctrl_q[GC_TOGGLE];
	wire logic spm_en     = gctrl_q[GC_SPM];
	wire logic armed      = gctrl_q[GC_ARM_DONE];
	wire gate_src_t src   = gate_src_t'(gctrl_q[GC_SRC_L +: 2]);

	// =====================================================================
	// gate source path; first sync stage only feeds the second
	wire logic c1_sel = cmp_sync_q[0] ? c1_sy_q[1] : c1_rt_q;
	wire logic c2_sel = cmp_sync_q[1] ? c2_sy_q[1] : c2_rt_q;
	wire logic t8_wrap = (t8_prev_q && gate_in.timer8 == 8'h00);

	logic gate_raw;
	always_comb begin
		case (src)
			SRC_PIN:        gate_raw = pin_sy_q[1];
			SRC_TIMER8_OVF: gate_raw = t8_wrap_q;
			SRC_CMP_ONE:    gate_raw = c1_sel;
			default:        gate_raw = c2_sel;
		endcase
	end

	wire logic gate_rise  = gate_raw && !gate_prev_q;
	wire logic toggle_d   = toggle_en ? (toggle_q ^ gate_rise) : 1'b0;
	wire logic gate_mid   = toggle_en ? toggle_q : gate_raw;
	wire logic gate_pold  = gate_pol ? gate_mid : !gate_mid;

	// single pulse: window opens on the active edge after arming, closes on trailing edge
	logic sp_open_q;
	wire logic act_rise   = gate_pold && !level_prev_q;
	wire logic act_fall   = !gate_pold && level_prev_q;
	wire logic sp_gate    = sp_open_q || (armed && act_rise);
	wire logic gate_act   = spm_en ? (sp_gate && gate_pold) : gate_pold;

	wire logic count_en   = timer_on && (!gate_en || gate_act);
	wire logic counting   = count_en && count_tick && (!sleep_mode || (ext_clk && no_sync));
	wire logic rollover   = counting && (count_q == COUNT_MAX[COUNT_W-1:0]);

	always_comb begin
		count_d = count_q;
		if (counting) count_d = count_q + 1'b1;
		if (wr_lo) count_d[7:0] = bus_req.wdata;
		if (wr_hi) count_d[15:8] = bus_req.wdata;
	end

	// gate control next value, hardware clears on top of writes; an arming write beats the end-of-pulse arm clear only while the arm bit is clear
	logic [7:0] gctrl_d;
	always_comb begin
		gctrl_d = gctrl_q;
		if (wr_gc) gctrl_d = {bus_req.wdata[7:3], 1'b0, bus_req.wdata[1:0]};
		if (spm_en && sp_open_q && act_fall && !(wr_gc && bus_req.wdata[GC_ARM_DONE] && !armed))
			gctrl_d[GC_ARM_DONE] = 1'b0;
		if (!gctrl_d[GC_SPM]) gctrl_d[GC_ARM_DONE] = 1'b0;
		gctrl_d[GC_LEVEL] = 1'b0;
	end

	// flags: hardware set wins over software clear
	wire logic act_fall_lvl = !gate_pold && level_q;
	logic [7:0] flag_d;
	always_comb begin
		flag_d = wr_pf ? (bus_req.wdata & 8'h81) : flag_q;
		if (rollover) flag_d[PF_OVF] = 1'b1;
		if (act_fall_lvl) flag_d[PF_GATE] = 1'b1;
	end

	wire logic ovf_irq  = flag_q[PF_OVF] && en_q[PF_OVF] && timer_on;
	wire logic gate_irq = flag_q[PF_GATE] && en_q[PF_GATE];
	wire logic per_irq  = (ovf_irq || gate_irq) && ictrl_q[IC_PERIPH];

	// read mux: count bytes come straight from the live count_q; low and high bytes are not latched together
	always_comb begin
		if (bus_req.addr == ADDR_COUNT_LOW) rdata_d = count_q[7:0];
		else if (bus_req.addr == ADDR_COUNT_HIGH) rdata_d = count_q[15:8];
		else if (bus_req.addr == ADDR_TIMER_CTRL) rdata_d = tctrl_q & 8'hfd;
		else if (bus_req.addr == ADDR_GATE_CTRL) rdata_d = {gctrl_q[7:3], level_q, gctrl_q[1:0]};
		else if (bus_req.addr == ADDR_PERIPH_FLAG) rdata_d = flag_q;
		else if (bus_req.addr == ADDR_PERIPH_EN) rdata_d = en_q;
		else if (bus_req.addr == ADDR_IRQ_CTRL) rdata_d = ictrl_q;
		else rdata_d = {6'h00, cmp_sync_q};
	end

	// =====================================================================
	// bus-side registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
		end else if (clk_en) begin
			count_q <= count_d;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tctrl_q <= TIMER_CTRL_RST;
		end else if (clk_en) begin
			if (wr_tc) tctrl_q <= bus_req.wdata & 8'hfd;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gctrl_q <= GATE_CTRL_RST;
		end else if (clk_en) begin
			gctrl_q <= gctrl_d;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= FLAG_RST;
		end else if (clk_en) begin
			flag_q <= flag_d;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= EN_RST;
		end else if (clk_en) begin
			if (wr_pe) en_q <= bus_req.wdata & 8'h81;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ictrl_q <= EN_RST;
		end else if (clk_en) begin
			if (wr_ic) ictrl_q <= bus_req.wdata & 8'hc0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_sync_q <= CMP_SYNC_RST;
		end else if (clk_en) begin
			if (wr_cs) cmp_sync_q <= bus_req.wdata[1:0];
		end
	end

	// read data only stands in the cycle after the strobe, zero otherwise
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (clk_en) begin
			rdata_q <= bus_req.rd ? rdata_d : 8'h00;
		end
	end

	// =====================================================================
	// gate source synchronisers; the first stage feeds only the second
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_sy_q <= 2'h0;
		end else if (clk_en) begin
			pin_sy_q <= {pin_sy_q[0], gate_in.gate_input_pin};
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			c1_sy_q <= 2'h0;
		end else if (clk_en) begin
			c1_sy_q <= {c1_sy_q[0], gate_in.cmp_one};
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			c2_sy_q <= 2'h0;
		end else if (clk_en) begin
			c2_sy_q <= {c2_sy_q[0], gate_in.cmp_two};
		end
	end

	// pass-through path trades metastability margin for one cycle less latency
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			c1_rt_q <= 1'b0;
		end else if (clk_en) begin
			c1_rt_q <= gate_in.cmp_one;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			c2_rt_q <= 1'b0;
		end else if (clk_en) begin
			c2_rt_q <= gate_in.cmp_two;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			t8_prev_q <= 1'b0;
		end else if (clk_en) begin
			if (gate_in.timer8_tick) t8_prev_q <= (gate_in.timer8 == TIMER8_MAX);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			t8_wrap_q <= 1'b0;
		end else if (clk_en) begin
			t8_wrap_q <= gate_in.timer8_tick && t8_wrap;
		end
	end

	// =====================================================================
	// gate mode state
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gate_prev_q <= 1'b0;
		end else if (clk_en) begin
			gate_prev_q <= gate_raw;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			toggle_q <= 1'b0;
		end else if (clk_en) begin
			toggle_q <= toggle_d;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			level_q <= 1'b0;
		end else if (clk_en) begin
			level_q <= gate_pold;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			level_prev_q <= 1'b0;
		end else if (clk_en) begin
			level_prev_q <= gate_pold;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sp_open_q <= 1'b0;
		end else if (clk_en) begin
			sp_open_q <= spm_en && sp_gate && !act_fall;
		end
	end

	// =====================================================================
	// interrupt and wake outputs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else if (clk_en) begin
			irq_q <= per_irq && ictrl_q[IC_GLOBAL];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wake_q <= 1'b0;
		end else if (clk_en) begin
			wake_q <= sleep_mode && per_irq;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			vec_q <= 1'b0;
		end else if (clk_en) begin
			vec_q <= sleep_mode && per_irq && ictrl_q[IC_GLOBAL];
		end
	end

	// oscillator request ignores sleep and the sync bit on purpose
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			osc_q <= 1'b0;
		end else if (clk_en) begin
			osc_q <= tctrl_q[TC_OSC_EN];
		end
	end

	assign rdata = rdata_q;
	assign irq_req = irq_q;
	assign wake_req = wake_q;
	assign wake_vector = vec_q;
	assign osc_run = osc_q;
	assign gate_level = level_q;

endmodule : gate_timer

// ==== verif/gate_timer_sva.sv ====
// checker: port-level assertions for the gated timer
`timescale 1ns/1ps
// ====================================
// checker module
module gate_timer_sva
	import gate_timer_pkg::*;
#(
	parameter int COUNT_W = 16
) (
	// design ports; clk_en, count_tick and irq_req are not observed
	input wire logic         mclk,
	input wire logic         rst_n,
	input wire logic         clk_en,
	input wire bus_req_t     bus_req,
	input wire logic [7:0]   rdata,
	input wire logic         count_tick,
	input wire logic         sleep_mode,
	input wire gate_inputs_t gate_in,
	input wire logic         irq_req,
	input wire logic         wake_req,
	input wire logic         wake_vector,
	input wire logic         osc_run,
	input wire logic         gate_level
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	wire tc_wr = bus_req.wr && bus_req.addr == ADDR_TIMER_CTRL;
	property p_rd_idle; !$past(bus_req.rd) |-> rdata == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero outside read");
	property p_tc_resv; bus_req.rd && bus_req.addr == ADDR_TIMER_CTRL |=> rdata[5:4] == 2'h0 && !rdata[1]; endproperty
	a_tc_resv: assert property (p_tc_resv) else $error("reserved control bits read set");
	property p_level_ro;
		bus_req.rd && bus_req.addr == ADDR_GATE_CTRL && $stable(gate_level) ##1 $stable(gate_level)
			|-> rdata[GC_LEVEL] == gate_level;
	endproperty
	a_level_ro: assert property (p_level_ro) else $error("level status bit differs from gate level");
	// six quiet cycles cover the input synchroniser latency
	property p_gate_hold; (!bus_req.wr && $stable(gate_in)) [*6] |-> $stable(gate_level); endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("gate level moved with quiet inputs");
	property p_osc_set; tc_wr ##1 !tc_wr |=> osc_run == $past(bus_req.wdata[TC_OSC_EN], 2); endproperty
	a_osc_set: assert property (p_osc_set) else $error("oscillator run differs from written bit");
	property p_osc_hold; $changed(osc_run) |-> $past(tc_wr) || $past(tc_wr, 2); endproperty
	a_osc_hold: assert property (p_osc_hold) else $error("oscillator run changed without write");
	property p_wake_vec; wake_vector |-> wake_req; endproperty
	a_wake_vec: assert property (p_wake_vec) else $error("vector without wake");
	property p_wake_sleep; wake_req |-> $past(sleep_mode); endproperty
	a_wake_sleep: assert property (p_wake_sleep) else $error("wake outside sleep");
endmodule : gate_timer_sva

bind gate_timer gate_timer_sva #(.COUNT_W(COUNT_W)) u_sva (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
	.bus_req(bus_req), .rdata(rdata), .count_tick(count_tick), .sleep_mode(sleep_mode), .gate_in(gate_in),
	.irq_req(irq_req), .wake_req(wake_req), .wake_vector(wake_vector), .osc_run(osc_run),
	.gate_level(gate_level));

// ==== verif/tb.sv ====
// testbench: directed self-checking tests for the gated timer
`timescale 1ns/1ps
// ====================================
// bench
module tb;
	import gate_timer_pkg::*;
	logic         mclk;
	logic         rst_n;
	logic         count_tick;
	logic         sleep_mode;
	bus_req_t     bus_req;
	gate_inputs_t gi;
	logic [7:0]   rdata;
	logic         irq_req, wake_req, wake_vector, osc_run, gate_level;
	logic [7:0]   v;
	logic [15:0]  c;
	int           errors;
	int           checks;
	gate_timer dut (.mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .bus_req(bus_req), .rdata(rdata),
		.count_tick(count_tick), .sleep_mode(sleep_mode), .gate_in(gi), .irq_req(irq_req),
		.wake_req(wake_req), .wake_vector(wake_vector), .osc_run(osc_run), .gate_level(gate_level));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	task ck(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : ck
	task ck1(input string n, input logic e, input logic g);
		ck(n, {15'h0000, e}, {15'h0000, g});
	endtask : ck1
	task w(input int n);
		repeat (n) @(posedge mclk);
	endtask : w
	// every driver starts on an edge, so two tasks never drive in one step
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge mclk);
		bus_req <= '0;
	endtask : wr
	task rd(input logic [2:0] a);
		@(posedge mclk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge mclk);
		bus_req <= '0;
		@(negedge mclk);
		v = rdata;
	endtask : rd
	task rc;
		rd(ADDR_COUNT_LOW);
		c[7:0] = v;
		rd(ADDR_COUNT_HIGH);
		c[15:8] = v;
	endtask : rc
	task tk(input int n);
		repeat (n) begin
			@(posedge mclk);
			count_tick <= 1'b1;
			@(posedge mclk);
			count_tick <= 1'b0;
		end
	endtask : tk
	task pin(input logic b);
		@(posedge mclk);
		gi.gate_input_pin <= b;
		w(5);
	endtask : pin
	task wrap;
		@(posedge mclk);
		gi.timer8 <= TIMER8_MAX;
		gi.timer8_tick <= 1'b1;
		@(posedge mclk);
		gi.timer8 <= 8'h00;
		@(posedge mclk);
		gi.timer8_tick <= 1'b0;
		w(5);
		@(negedge mclk);
	endtask : wrap
	// the count is only written with the timer stopped
	task cnt0;
		wr(ADDR_TIMER_CTRL, 8'h00);
		wr(ADDR_COUNT_LOW, 8'h00);
		wr(ADDR_COUNT_HIGH, 8'h00);
		wr(ADDR_TIMER_CTRL, 8'h01);
	endtask : cnt0
	// ====================================
	// scenarios
	task t_ovf;
		wr(ADDR_COUNT_LOW, 8'hfe);
		wr(ADDR_COUNT_HIGH, 8'hff);
		tk(2);
		rc;
		ck("count while off", 16'hfffe, c);
		wr(ADDR_TIMER_CTRL, 8'h09);
		wr(ADDR_PERIPH_EN, 8'h01);
		wr(ADDR_IRQ_CTRL, 8'hc0);
		tk(3);
		rc;
		ck("count rollover", 16'h0001, c);
		rd(ADDR_PERIPH_FLAG);
		ck1("overflow flag", 1'b1, v[PF_OVF]);
		ck1("irq all enabled", 1'b1, irq_req);
		wr(ADDR_IRQ_CTRL, 8'h40);
		w(2);
		@(negedge mclk);
		ck1("irq no global", 1'b0, irq_req);
		@(posedge mclk);
		sleep_mode <= 1'b1;
		w(3);
		@(negedge mclk);
		ck1("wake", 1'b1, wake_req);
		ck1("no vector", 1'b0, wake_vector);
		ck1("osc in sleep", 1'b1, osc_run);
		wr(ADDR_IRQ_CTRL, 8'hc0);
		w(2);
		@(negedge mclk);
		ck1("vector", 1'b1, wake_vector);
		tk(2);
		rc;
		ck("no count in sleep", 16'h0001, c);
		wr(ADDR_TIMER_CTRL, 8'h8d);
		tk(2);
		rc;
		ck("count in sleep", 16'h0003, c);
		ck1("osc no sync", 1'b1, osc_run);
		@(posedge mclk);
		sleep_mode <= 1'b0;
		wr(ADDR_IRQ_CTRL, 8'h00);
		wr(ADDR_PERIPH_FLAG, 8'h00);
		$display("t_ovf done");
	endtask : t_ovf
	task t_gate;
		cnt0;
		wr(ADDR_GATE_CTRL, 8'h80);
		pin(1'b1);
		tk(3);
		rc;
		ck("held low pol", 16'h0000, c);
		pin(1'b0);
		tk(3);
		rc;
		ck("counted low pol", 16'h0003, c);
		wr(ADDR_GATE_CTRL, 8'hc0);
		w(5);
		tk(2);
		rc;
		ck("held high pol", 16'h0003, c);
		$display("t_gate done");
	endtask : t_gate
	task t_src;
		wr(ADDR_CMP_SYNC, 8'h01);
		for (int s = 2; s < 4; s++) begin
			wr(ADDR_GATE_CTRL, 8'h40 | 8'(s));
			gi.cmp_one <= (s == 2);
			gi.cmp_two <= (s == 3);
			w(5);
			@(negedge mclk);
			ck1("comparator high", 1'b1, gate_level);
			@(posedge mclk);
			gi.cmp_one <= 1'b0;
			gi.cmp_two <= 1'b0;
			w(5);
			@(negedge mclk);
			ck1("comparator low", 1'b0, gate_level);
		end
		wr(ADDR_GATE_CTRL, 8'h61);
		wrap;
		ck1("toggle after wrap", 1'b1, gate_level);
		wr(ADDR_GATE_CTRL, 8'h41);
		wr(ADDR_GATE_CTRL, 8'h61);
		w(5);
		@(negedge mclk);
		ck1("toggle cleared", 1'b0, gate_level);
		wrap;
		ck1("toggle again", 1'b1, gate_level);
		wrap;
		ck1("toggle twice", 1'b0, gate_level);
		$display("t_src done");
	endtask : t_src
	task t_event;
		wr(ADDR_GATE_CTRL, 8'h40);
		pin(1'b1);
		wr(ADDR_PERIPH_FLAG, 8'h00);
		rd(ADDR_PERIPH_FLAG);
		ck1("no event", 1'b0, v[PF_GATE]);
		ck1("level gate off", 1'b1, gate_level);
		pin(1'b0);
		rd(ADDR_PERIPH_FLAG);
		ck1("event flag", 1'b1, v[PF_GATE]);
		wr(ADDR_IRQ_CTRL, 8'hc0);
		w(2);
		@(negedge mclk);
		ck1("gate irq masked", 1'b0, irq_req);
		wr(ADDR_PERIPH_EN, 8'h80);
		w(2);
		@(negedge mclk);
		ck1("gate irq", 1'b1, irq_req);
		wr(ADDR_IRQ_CTRL, 8'h00);
		$display("t_event done");
	endtask : t_event
	task t_single;
		cnt0;
		wr(ADDR_GATE_CTRL, 8'hd0);
		wr(ADDR_GATE_CTRL, 8'hd8);
		pin(1'b1);
		tk(3);
		pin(1'b0);
		rd(ADDR_GATE_CTRL);
		ck1("arm cleared", 1'b0, v[GC_ARM_DONE]);
		pin(1'b1);
		tk(2);
		pin(1'b0);
		rc;
		ck("one pulse counted", 16'h0003, c);
		wr(ADDR_GATE_CTRL, 8'hd8);
		rd(ADDR_GATE_CTRL);
		ck1("armed", 1'b1, v[GC_ARM_DONE]);
		wr(ADDR_GATE_CTRL, 8'hc0);
		rd(ADDR_GATE_CTRL);
		ck1("arm off with mode", 1'b0, v[GC_ARM_DONE]);
		$display("t_single done");
	endtask : t_single
	task give_verdict;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		w(6000);
		errors++;
		give_verdict;
	end
	initial begin
		errors = 0;
		checks = 0;
		rst_n = 1'b0;
		count_tick = 1'b0;
		sleep_mode = 1'b0;
		bus_req = '0;
		gi = '0;
		gi.gate_input_pin = 1'b1;
		w(12);
		rst_n <= 1'b1;
		rd(ADDR_CMP_SYNC);
		ck("sync select reset", {8'h00, 6'h00, CMP_SYNC_RST}, {8'h00, v});
		t_ovf;
		t_gate;
		t_src;
		t_event;
		t_single;
		give_verdict;
	end
endmodule : tb
